// File: limit_manager_defines.vh
// Constants for the dual axis limit switch manager
`ifndef LIMIT_MANAGER_DEFINES_VH
`define LIMIT_MANAGER_DEFINES_VH

// Clock rate and scan period
`define CLK_HZ 40000000
`define SCAN_PERIOD_US 1000
`define SCAN_CYCLES ((`CLK_HZ / 1000000) * `SCAN_PERIOD_US)
`define SCAN_CNT_W 16
`define SCAN_PERIOD_MS (`SCAN_PERIOD_US / 1000)

// Synchroniser reset: switches read "not reached", the rest low
`define SYNC_RESET 15'h00FF

// Speed feedback limits in rpm
`define SPEED_W 16
`define SPEED_MAX 16'sd6000
`define SPEED_MIN -16'sd6000

// Distance format: unsigned micrometres
`define DIST_W 32
`define DIST_ZERO 32'h00000000
`define DIST_MAX 32'hFFFFFFFF

// Motor parameter fields, each a 16-bit word
`define PARAM_W 16
`define SCALE_DEFAULT 16'h0064
`define PERCENT 100

// Scan period in micrometre-ready form (ms times 1000)
`define SCAN_PERIOD_MS_X1000 `SCAN_PERIOD_US

`endif

// File: scan_divider.v
// Scan cycle enable divider
`timescale 1ns/1ps
`default_nettype none
`include "limit_manager_defines.vh"

module scan_divider
(
  input wire clk,
  input wire rst_n,
  input wire run,
  output reg tick
);

  reg [`SCAN_CNT_W-1:0] count;

  // One pulse per scan; held in reset while not running
  always @(posedge clk)
  begin
    if (!rst_n || !run)
    begin
      count <= {`SCAN_CNT_W{1'b0}};
      tick <= 1'b0;
    end
    else if (count == `SCAN_CYCLES - 1)
    begin
      count <= {`SCAN_CNT_W{1'b0}};
      tick <= 1'b1;
    end
    else
    begin
      count <= count + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule // scan_divider

`default_nettype wire

// File: distance_integrator.v
// Per-axis travelled distance integrator
`timescale 1ns/1ps
`default_nettype none
`include "limit_manager_defines.vh"

module distance_integrator
(
  input wire clk,
  input wire rst_n,
  input wire clear,
  input wire tick,
  input wire active,
  input wire signed [`SPEED_W-1:0] speed,
  input wire [`PARAM_W-1:0] nominal_rpm,
  input wire [`PARAM_W-1:0] linear_mm_s,
  input wire [`PARAM_W-1:0] scale_pct,
  output reg [`DIST_W-1:0] travelled
);

  // Magnitude of speed, clipped to the documented range
  function [15:0] speed_mag;
    input signed [15:0] s;
    reg signed [15:0] c;
    begin
      c = (s > `SPEED_MAX) ? `SPEED_MAX : (s < `SPEED_MIN) ? `SPEED_MIN : s;
      speed_mag = c[15] ? -c : c;
    end
  endfunction

  wire [15:0] mag;
  wire [63:0] numer;
  wire [63:0] step;
  wire [32:0] sum;

  // Period and unity scale held at the width of the products
  localparam [63:0] PERIOD_MS = `SCAN_PERIOD_MS;
  localparam [63:0] UNITY_PCT = `PERCENT;

  assign mag = speed_mag(speed);
  // um = pct/100 * mm/s * rpm * ms / nominal  (mm*ms = um)
  assign numer = {48'h0, scale_pct} * {48'h0, linear_mm_s} *
                 {48'h0, mag} * PERIOD_MS;
  // Zero nominal speed would divide by zero; treat as no motion
  assign step = (nominal_rpm == 16'h0000) ? 64'h0 :
                numer / (UNITY_PCT * {48'h0, nominal_rpm});
  assign sum = {1'b0, travelled} + {1'b0, step[31:0]};

  // Sum increments each active scan, saturating at full scale
  always @(posedge clk)
  begin
    if (!rst_n || clear)
      travelled <= `DIST_ZERO;
    else if (tick && active)
      travelled <= (sum[32] || step[63:32] != 32'h0) ? `DIST_MAX : sum[31:0];
  end

endmodule // distance_integrator

`default_nettype wire

// File: dual_axis_limit_switch_manager.v
// Limit switch manager for a primary and a secondary axis
`timescale 1ns/1ps
`default_nettype none
`include "limit_manager_defines.vh"

// Behaviour
// - Block works only while enabled; otherwise all outputs but the sync echo are off.
// - Sync input selects synchronous or independent axis operation.
// - Primary forward stop reached drops primary forward run.
// - Primary reverse stop reached drops primary reverse run.
// - Primary forward slow reached raises primary forward slow.
// - Primary reverse slow reached raises primary reverse slow.
// - Primary commands drive primary runs, and secondary runs in sync.
// - Secondary commands ignored in sync, used in independent mode.
// - Primary speed feedback is signed rpm within plus/minus 6000.
// - Secondary speed feedback signed rpm, used for distance stop and range alarm.
// - Secondary forward stop reached drops secondary forward run.
// - Secondary reverse stop reached drops secondary reverse run.
// - Secondary forward slow reached raises secondary forward slow.
// - Secondary reverse slow reached raises secondary reverse slow.
// - Motor parameter words 0 to 65535 feed only distance calculation.
// - Alarm clear rising edge clears alarms whose cause has gone.
// - In sync, either axis's slow or stop switch acts on both.
// - After slow switch, integrate speed; stop when distance reached.
// - Increment is scale times linear times actual times period per nominal.
module dual_axis_limit_switch_manager
(
  input wire clk,
  input wire rst_n,
  input wire block_enable_in,
  input wire sync_mode_in,
  input wire primary_fwd_stop_sw,
  input wire primary_rev_stop_sw,
  input wire primary_fwd_slow_sw,
  input wire primary_rev_slow_sw,
  input wire primary_fwd_cmd_in,
  input wire primary_rev_cmd_in,
  input wire signed [`SPEED_W-1:0] primary_speed_feedback,
  input wire [`DIST_W-1:0] primary_stop_distance,
  input wire secondary_fwd_stop_sw,
  input wire secondary_rev_stop_sw,
  input wire secondary_fwd_slow_sw,
  input wire secondary_rev_slow_sw,
  input wire secondary_fwd_cmd_in,
  input wire secondary_rev_cmd_in,
  input wire [`DIST_W-1:0] secondary_stop_distance,
  input wire signed [`SPEED_W-1:0] secondary_speed_feedback,
  input wire [`PARAM_W-1:0] primary_nominal_rpm,
  input wire [`PARAM_W-1:0] primary_linear_mm_s,
  input wire [`PARAM_W-1:0] primary_scale_pct,
  input wire [`PARAM_W-1:0] secondary_nominal_rpm,
  input wire [`PARAM_W-1:0] secondary_linear_mm_s,
  input wire [`PARAM_W-1:0] secondary_scale_pct,
  input wire alarm_clear_in,
  output reg primary_fwd_run_out,
  output reg primary_rev_run_out,
  output reg primary_fwd_slow_out,
  output reg primary_rev_slow_out,
  output reg secondary_fwd_run_out,
  output reg secondary_rev_run_out,
  output reg secondary_fwd_slow_out,
  output reg secondary_rev_slow_out,
  output reg enabled_out,
  output reg sync_active_out,
  output reg [`DIST_W-1:0] primary_travelled_out,
  output reg [`DIST_W-1:0] secondary_travelled_out,
  output reg alarm_out
);

  // ****************************************************
  // Input synchronisers
  // ****************************************************

  // Switches and commands come from outside the clock domain
  localparam NIN = 15;
  wire [NIN-1:0] raw_in;
  reg [NIN-1:0] sync_a;
  reg [NIN-1:0] sync_b;

  assign raw_in = {alarm_clear_in, sync_mode_in, block_enable_in,
                   secondary_rev_cmd_in, secondary_fwd_cmd_in,
                   primary_rev_cmd_in, primary_fwd_cmd_in,
                   secondary_rev_slow_sw, secondary_fwd_slow_sw,
                   secondary_rev_stop_sw, secondary_fwd_stop_sw,
                   primary_rev_slow_sw, primary_fwd_slow_sw,
                   primary_rev_stop_sw, primary_fwd_stop_sw};

  // Two flops; the first is read only by the second.
  // Switches reset to "not reached", commands and modes to off, so
  // leaving reset gives no run pulse and no false clear edge
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync_a <= `SYNC_RESET;
      sync_b <= `SYNC_RESET;
    end
    else
    begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  // Synchronised copies; a low switch means "reached"
  wire p_fwd_stop_ok = sync_b[0];
  wire p_rev_stop_ok = sync_b[1];
  wire p_fwd_slow_ok = sync_b[2];
  wire p_rev_slow_ok = sync_b[3];
  wire s_fwd_stop_ok = sync_b[4];
  wire s_rev_stop_ok = sync_b[5];
  wire s_fwd_slow_ok = sync_b[6];
  wire s_rev_slow_ok = sync_b[7];
  wire p_fwd_cmd = sync_b[8];
  wire p_rev_cmd = sync_b[9];
  wire s_fwd_cmd = sync_b[10];
  wire s_rev_cmd = sync_b[11];
  wire en = sync_b[12];
  wire sync_mode = sync_b[13];
  wire clr_lvl = sync_b[14];

  // ****************************************************
  // Scan timing
  // ****************************************************

  wire tick;

  scan_divider u_scan
  (
    .clk(clk),
    .rst_n(rst_n),
    .run(en),
    .tick(tick)
  );

  // ****************************************************
  // Switch combination per mode
  // ****************************************************

  // Reached on this axis, or on either axis while tied together.
  // One place for the rule keeps the four directions from drifting.
  function reached_any;
    input tied;
    input own_ok;
    input other_ok;
    begin
      reached_any = tied ? !(own_ok && other_ok) : !own_ok;
    end
  endfunction

  // In sync the worse of the two axes governs both
  wire pf_stop = reached_any(sync_mode, p_fwd_stop_ok, s_fwd_stop_ok);
  wire pr_stop = reached_any(sync_mode, p_rev_stop_ok, s_rev_stop_ok);
  wire pf_slow = reached_any(sync_mode, p_fwd_slow_ok, s_fwd_slow_ok);
  wire pr_slow = reached_any(sync_mode, p_rev_slow_ok, s_rev_slow_ok);
  wire sf_stop = sync_mode ? pf_stop : !s_fwd_stop_ok;
  wire sr_stop = sync_mode ? pr_stop : !s_rev_stop_ok;
  wire sf_slow = sync_mode ? pf_slow : !s_fwd_slow_ok;
  wire sr_slow = sync_mode ? pr_slow : !s_rev_slow_ok;

  // Secondary follows primary commands in sync
  wire sf_cmd = sync_mode ? p_fwd_cmd : s_fwd_cmd;
  wire sr_cmd = sync_mode ? p_rev_cmd : s_rev_cmd;

  // ****************************************************
  // Stop-on-distance
  // ****************************************************

  // Zero distance turns the feature off for that axis
  wire p_sod_on = (primary_stop_distance != `DIST_ZERO);
  wire s_sod_on = (secondary_stop_distance != `DIST_ZERO);

  // Integrate while in a slow zone and moving that way
  wire p_zone = (pf_slow && p_fwd_cmd) || (pr_slow && p_rev_cmd);
  wire s_zone = (sf_slow && sf_cmd) || (sr_slow && sr_cmd);
  wire p_clear = !en || !p_sod_on || !(pf_slow || pr_slow);
  wire s_clear = !en || !s_sod_on || !(sf_slow || sr_slow);
  wire [`DIST_W-1:0] p_dist;
  wire [`DIST_W-1:0] s_dist;

  distance_integrator u_p_dist
  (
    .clk(clk),
    .rst_n(rst_n),
    .clear(p_clear),
    .tick(tick),
    .active(p_zone),
    .speed(primary_speed_feedback),
    .nominal_rpm(primary_nominal_rpm),
    .linear_mm_s(primary_linear_mm_s),
    .scale_pct(primary_scale_pct),
    .travelled(p_dist)
  );

  distance_integrator u_s_dist
  (
    .clk(clk),
    .rst_n(rst_n),
    .clear(s_clear),
    .tick(tick),
    .active(s_zone),
    .speed(secondary_speed_feedback),
    .nominal_rpm(secondary_nominal_rpm),
    .linear_mm_s(secondary_linear_mm_s),
    .scale_pct(secondary_scale_pct),
    .travelled(s_dist)
  );

  // ****************************************************
  // Distance compare
  // ****************************************************

  // Distance reached blocks the direction of the slow zone
  wire p_far = p_sod_on && (p_dist >= primary_stop_distance);
  wire s_far = s_sod_on && (s_dist >= secondary_stop_distance);
  wire p_far_f = p_far && pf_slow;
  wire p_far_r = p_far && pr_slow;
  wire s_far_f = s_far && sf_slow;
  wire s_far_r = s_far && sr_slow;
  // A distance stop on either axis holds both when synchronised
  wire pf_block = pf_stop || p_far_f || (sync_mode && s_far_f);
  wire pr_block = pr_stop || p_far_r || (sync_mode && s_far_r);
  wire sf_block = sf_stop || s_far_f || (sync_mode && p_far_f);
  wire sr_block = sr_stop || s_far_r || (sync_mode && p_far_r);

  // ****************************************************
  // Alarms
  // ****************************************************

  // Feedback outside the plus/minus 6000 rpm window
  function speed_bad;
    input signed [`SPEED_W-1:0] s;
    begin
      speed_bad = (s > `SPEED_MAX) || (s < `SPEED_MIN);
    end
  endfunction

  // Cause: both directions commanded, or feedback out of range
  wire cause = (p_fwd_cmd && p_rev_cmd) ||
               (!sync_mode && s_fwd_cmd && s_rev_cmd) ||
               speed_bad(primary_speed_feedback) ||
               speed_bad(secondary_speed_feedback);
  reg clr_prev;
  wire clr_edge = clr_lvl && !clr_prev;
  reg next_alarm;

  // A live cause beats the clear edge
  always @*
  begin
    next_alarm = alarm_out;
    if (clr_edge)
      next_alarm = 1'b0;
    if (cause)
      next_alarm = 1'b1;
  end

  // ****************************************************
  // Output registers
  // ****************************************************

  // Next drive levels
  reg next_pf_run;
  reg next_pr_run;
  reg next_pf_slow;
  reg next_pr_slow;
  reg next_sf_run;
  reg next_sr_run;
  reg next_sf_slow;
  reg next_sr_slow;

  // Disabled leaves every drive output low
  always @*
  begin
    next_pf_run = 1'b0;
    next_pr_run = 1'b0;
    next_pf_slow = 1'b0;
    next_pr_slow = 1'b0;
    next_sf_run = 1'b0;
    next_sr_run = 1'b0;
    next_sf_slow = 1'b0;
    next_sr_slow = 1'b0;
    if (en)
    begin
      next_pf_run = p_fwd_cmd && !pf_block;
      next_pr_run = p_rev_cmd && !pr_block;
      next_pf_slow = pf_slow;
      next_pr_slow = pr_slow;
      next_sf_run = sf_cmd && !sf_block;
      next_sr_run = sr_cmd && !sr_block;
      next_sf_slow = sf_slow;
      next_sr_slow = sr_slow;
    end
  end

  // Drive outputs straight from flops, so drives never see a glitch
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      primary_fwd_run_out <= 1'b0;
      primary_rev_run_out <= 1'b0;
      primary_fwd_slow_out <= 1'b0;
      primary_rev_slow_out <= 1'b0;
      secondary_fwd_run_out <= 1'b0;
      secondary_rev_run_out <= 1'b0;
      secondary_fwd_slow_out <= 1'b0;
      secondary_rev_slow_out <= 1'b0;
    end
    else
    begin
      primary_fwd_run_out <= next_pf_run;
      primary_rev_run_out <= next_pr_run;
      primary_fwd_slow_out <= next_pf_slow;
      primary_rev_slow_out <= next_pr_slow;
      secondary_fwd_run_out <= next_sf_run;
      secondary_rev_run_out <= next_sr_run;
      secondary_fwd_slow_out <= next_sf_slow;
      secondary_rev_slow_out <= next_sr_slow;
    end
  end

  // Status echoes, distances and alarm; all but the sync echo cleared while disabled
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      enabled_out <= 1'b0;
      sync_active_out <= 1'b0;
      primary_travelled_out <= `DIST_ZERO;
      secondary_travelled_out <= `DIST_ZERO;
      alarm_out <= 1'b0;
      clr_prev <= 1'b0;
    end
    else
    begin
      enabled_out <= en;
      sync_active_out <= sync_mode;
      primary_travelled_out <= en ? p_dist : `DIST_ZERO;
      secondary_travelled_out <= en ? s_dist : `DIST_ZERO;
      alarm_out <= en && next_alarm;
      clr_prev <= clr_lvl;
    end
  end

endmodule // dual_axis_limit_switch_manager

`default_nettype wire

// File: axis_field_model.sv
// Field model of one axis: NC limit switches and drive speed feedback
`timescale 1ns/1ps
`default_nettype none
`include "limit_manager_defines.vh"
// ****************
// Axis field model
// ****************
module axis_field_model
(
  input wire logic clk,
  input wire logic [3:0] reached,
  input wire logic fwd_run,
  input wire logic rev_run,
  input wire logic signed [`SPEED_W-1:0] rpm_set,
  output logic [3:0] sw,
  output logic signed [`SPEED_W-1:0] speed
);
  // Contact opens when reached, so a reached switch reads low
  assign sw = ~reached;
  initial speed = 16'sh0000;
  // Drive lags its run command by one clock, never instantly
  always @(posedge clk)
  begin
    speed <= fwd_run ? rpm_set : (rev_run ? -rpm_set : 16'sh0000);
  end
endmodule // axis_field_model
`default_nettype wire

// File: limit_manager_checker.sv
// Port level assertions for the limit switch manager
`timescale 1ns/1ps
`default_nettype none
`include "limit_manager_defines.vh"
// ************
// Port checker
// ************
module limit_manager_checker
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic block_enable_in,
  input wire logic sync_mode_in,
  input wire logic primary_fwd_stop_sw,
  input wire logic primary_rev_stop_sw,
  input wire logic primary_fwd_slow_sw,
  input wire logic primary_fwd_cmd_in,
  input wire logic secondary_fwd_stop_sw,
  input wire logic secondary_fwd_slow_sw,
  input wire logic secondary_fwd_cmd_in,
  input wire logic secondary_rev_cmd_in,
  input wire logic primary_fwd_run_out,
  input wire logic primary_rev_run_out,
  input wire logic primary_fwd_slow_out,
  input wire logic secondary_fwd_run_out,
  input wire logic alarm_out,
  input wire logic [`DIST_W-1:0] primary_travelled_out
);
  // Inputs reach outputs three edges later, hence four samples
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_pfwd_stop_low: assert property ((!primary_fwd_stop_sw)[*4]
    |-> !primary_fwd_run_out) else $error("fwd stop ignored");
  chk_prev_stop_low: assert property ((!primary_rev_stop_sw)[*4]
    |-> !primary_rev_run_out) else $error("rev stop ignored");
  chk_pfwd_slow_set: assert property (
    (block_enable_in && !primary_fwd_slow_sw)[*4] |-> primary_fwd_slow_out)
    else $error("fwd slow missing");
  chk_sfwd_stop_low: assert property ((!secondary_fwd_stop_sw)[*4]
    |-> !secondary_fwd_run_out) else $error("secondary stop ignored");
  chk_off_all_quiet: assert property ((!block_enable_in)[*4] |->
    !(primary_fwd_run_out || secondary_fwd_run_out || primary_fwd_slow_out)
    && primary_travelled_out == 0) else $error("active while disabled");
  chk_sync_cmd_ignored: assert property (
    (block_enable_in && sync_mode_in && !primary_fwd_cmd_in)[*4]
    |-> !secondary_fwd_run_out) else $error("secondary cmd used in sync");
  chk_sync_slow_shared: assert property (
    (block_enable_in && sync_mode_in && !secondary_fwd_slow_sw)[*4]
    |-> primary_fwd_slow_out) else $error("slow not shared");
  chk_async_own_cmd: assert property ((block_enable_in && !sync_mode_in
    && secondary_fwd_cmd_in && !secondary_rev_cmd_in && secondary_fwd_stop_sw
    && secondary_fwd_slow_sw && !alarm_out)[*4] |-> secondary_fwd_run_out)
    else $error("secondary cmd lost");
endmodule // limit_manager_checker
bind dual_axis_limit_switch_manager limit_manager_checker
  limit_manager_checker_inst (.*);
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the dual axis limit switch manager
`timescale 1ns/1ps
`default_nettype none
`include "limit_manager_defines.vh"
// *****
// Bench
// *****
module tb_top;
  localparam logic [15:0] nom = 16'h05DC, lin = 16'h03E8, scl = 16'h0064;
  localparam logic [31:0] step_um = scl * lin * nom / (32'h00000064 * nom);
  logic clk = 1'b0, rst_n = 1'b0, block_enable_in = 1'b0;
  logic sync_mode_in = 1'b0, alarm_clear_in = 1'b0;
  logic primary_fwd_cmd_in = 1'b0, primary_rev_cmd_in = 1'b0;
  logic secondary_fwd_cmd_in = 1'b0, secondary_rev_cmd_in = 1'b0;
  logic [3:0] reach_p = 4'h0, reach_s = 4'h0, sw_p, sw_s;
  logic signed [`SPEED_W-1:0] rpm = 16'sh05DC;
  wire signed [`SPEED_W-1:0] primary_speed_feedback, secondary_speed_feedback;
  wire primary_fwd_stop_sw, primary_rev_stop_sw;
  wire primary_fwd_slow_sw, primary_rev_slow_sw;
  wire secondary_fwd_stop_sw, secondary_rev_stop_sw;
  wire secondary_fwd_slow_sw, secondary_rev_slow_sw;
  logic [`DIST_W-1:0] primary_stop_distance = 32'h00000000;
  logic [`DIST_W-1:0] secondary_stop_distance = 32'h00000000;
  logic [`PARAM_W-1:0] primary_nominal_rpm = nom, secondary_nominal_rpm = nom;
  logic [`PARAM_W-1:0] primary_linear_mm_s = lin, secondary_linear_mm_s = lin;
  logic [`PARAM_W-1:0] primary_scale_pct = scl, secondary_scale_pct = scl;
  logic primary_fwd_run_out, primary_rev_run_out;
  logic primary_fwd_slow_out, primary_rev_slow_out;
  logic secondary_fwd_run_out, secondary_rev_run_out;
  logic secondary_fwd_slow_out, secondary_rev_slow_out;
  logic enabled_out, sync_active_out, alarm_out;
  logic [`DIST_W-1:0] primary_travelled_out, secondary_travelled_out;
  logic [7:0] outs;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Outputs in one vector so each step compares all eight at once
  assign outs = {primary_fwd_run_out, primary_rev_run_out, primary_fwd_slow_out,
    primary_rev_slow_out, secondary_fwd_run_out, secondary_rev_run_out,
    secondary_fwd_slow_out, secondary_rev_slow_out};
  assign {primary_rev_slow_sw, primary_fwd_slow_sw, primary_rev_stop_sw,
    primary_fwd_stop_sw} = sw_p;
  assign {secondary_rev_slow_sw, secondary_fwd_slow_sw, secondary_rev_stop_sw,
    secondary_fwd_stop_sw} = sw_s;
  dual_axis_limit_switch_manager dual_axis_limit_switch_manager_inst (.*);
  axis_field_model axis_field_model_inst (.clk(clk), .reached(reach_p),
    .fwd_run(primary_fwd_run_out), .rev_run(primary_rev_run_out),
    .rpm_set(rpm), .sw(sw_p), .speed(primary_speed_feedback));
  axis_field_model axis_field_model_inst_b (.clk(clk), .reached(reach_s),
    .fwd_run(secondary_fwd_run_out), .rev_run(secondary_rev_run_out),
    .rpm_set(rpm), .sw(sw_s), .speed(secondary_speed_feedback));
  always #12.5 clk = ~clk;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One distance tick is 40000 clocks, so the ceiling leaves room for one
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      err_count++;
      $display("BAD %0t run hung", $time);
      test_done;
    end
  end
  // Apply switches and commands, then let the three-edge path settle
  task step(input logic [3:0] rp, rs, c, input logic [7:0] exp);
    reach_p = rp;
    reach_s = rs;
    {secondary_rev_cmd_in, secondary_fwd_cmd_in, primary_rev_cmd_in,
      primary_fwd_cmd_in} = c;
    repeat (6) @(negedge clk);
    check(outs, exp);
  endtask
  task t_primary;
    step(4'h0, 4'h0, 4'h1, 8'h80);
    check(enabled_out, 1'b1);
    step(4'h4, 4'h0, 4'h1, 8'hA0);
    step(4'h5, 4'h0, 4'h1, 8'h20);
    step(4'h8, 4'h0, 4'h2, 8'h50);
    step(4'hA, 4'h0, 4'h2, 8'h10);
    $display("primary limits done");
  endtask
  task t_secondary;
    step(4'h0, 4'h0, 4'h4, 8'h08);
    step(4'h0, 4'h4, 4'h4, 8'h0A);
    step(4'h0, 4'h5, 4'h4, 8'h02);
    step(4'h0, 4'h8, 4'h8, 8'h05);
    step(4'h0, 4'hA, 4'h8, 8'h01);
    $display("secondary limits done");
  endtask
  task t_sync;
    sync_mode_in = 1'b1;
    step(4'h0, 4'h0, 4'h1, 8'h88);
    check(sync_active_out, 1'b1);
    step(4'h0, 4'h0, 4'h4, 8'h00);
    step(4'h0, 4'h4, 4'h1, 8'hAA);
    step(4'h0, 4'h1, 4'h1, 8'h00);
    step(4'h8, 4'h0, 4'h2, 8'h55);
    sync_mode_in = 1'b0;
    $display("sync mode done");
  endtask
  // Clear pulse with the cause present, then with it gone
  task t_alarm;
    step(4'h0, 4'h0, 4'h3, 8'hC0);
    check(alarm_out, 1'b1);
    alarm_clear_in = 1'b1;
    step(4'h0, 4'h0, 4'h3, 8'hC0);
    check(alarm_out, 1'b1);
    alarm_clear_in = 1'b0;
    step(4'h0, 4'h0, 4'h0, 8'h00);
    check(alarm_out, 1'b1);
    alarm_clear_in = 1'b1;
    step(4'h0, 4'h0, 4'h0, 8'h00);
    check(alarm_out, 1'b0);
    alarm_clear_in = 1'b0;
    $display("alarm done");
  endtask
  task t_distance;
    int n;
    primary_stop_distance = 32'h000001F4;
    step(4'h4, 4'h4, 4'h5, 8'hAA);
    for (n = 0; n < 45000 && primary_fwd_run_out !== 1'b0; n++)
      @(negedge clk);
    repeat (2) @(negedge clk);
    check(outs, 8'h2A);
    check(secondary_travelled_out, 32'h00000000);
    check(primary_travelled_out, step_um);
    $display("distance stop done");
  endtask
  task t_disable;
    block_enable_in = 1'b0;
    step(4'h4, 4'h0, 4'h5, 8'h00);
    check(primary_travelled_out, 32'h00000000);
    check(secondary_travelled_out, 32'h00000000);
    check(enabled_out, 1'b0);
    $display("disable done");
  endtask
  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    check(outs, 8'h00);
    block_enable_in = 1'b1;
    t_primary;
    t_secondary;
    t_sync;
    t_alarm;
    t_distance;
    t_disable;
    test_done;
  end
endmodule // tb_top
`default_nettype wire
